// File: rtl/csrb_core_special_register_bank.v
// Purpose: core special-function register bank of an 8-bit micro
// Assumes: one instruction executes per enabled step from the core
// Notes: general purpose ram of the bank lives here too
//
// What this block does
// - indirect port has no storage; access goes to pointed register
// - timer0_count reads live count; a write replaces the count
// - timer0 counts instruction clock, external pin or low oscillator
// - pc_low is pc low byte; pc steps by one unless loaded or held
// - pc bits 9:8 change by stepping, far loads, near jump bit 8 from the word, or from the pc_high_buffer bits
// - near jump: pc 8:0 from word, bit 9 from buffer bit 1
// - short call: pc 7:0 from word, 9:8 from buffer; push pc+1
// - far jump and far call load all ten bits; call pushes pc+1
// - carry set on add carry or subtract without borrow
// - half carry set on nibble carry or no nibble borrow
// - zero set when logical result is zero, else cleared
// - powered_down_flag set at power-up and watchdog clear; sleep clears
// - watchdog_timeout_flag set at power-up, clear, sleep; timeout clears
// - low six pointer bits choose one of 64 locations
// - bank_select bits have no addressing effect
// - port read gives pin for inputs; latch or pin for outputs
// - port write stores into the six output latches
// - ext_int_select makes pin 0 the external interrupt input
// - watchdog_enable turns the watchdog on; resets to one
// - low-voltage detect and reset enables; reset to zero and one
// - six pin_wakeup_enable bits gate wake-up; reset to one
`timescale 1ns/1ns
`include "csrb_consts.vh"
module csrb_core_special_register_bank (
  clk_sys,
  rst_b,
  step,
  rd_en,
  wr_en,
  addr,
  wdata,
  rdata,
  pc_op,
  instr_target,
  pc,
  push_valid,
  push_addr,
  flag_we,
  flag_c,
  flag_dc,
  flag_z_we,
  flag_z,
  clrwdt_exec,
  sleep_exec,
  wdt_timeout,
  t0_src,
  t0_falling,
  ext_timer_clock_pin,
  low_osc_clk,
  port_read_source_option,
  pin_is_output,
  port_b_pin,
  port_b_out,
  ext_int_select,
  watchdog_enable,
  low_volt_detect_enable,
  low_volt_reset_enable,
  pin_wakeup_enable
);
  input wire clk_sys;
  input wire rst_b;
  input wire step;
  input wire rd_en;
  input wire wr_en;
  input wire [5:0] addr;
  input wire [7:0] wdata;
  output reg [7:0] rdata;
  input wire [2:0] pc_op;
  input wire [9:0] instr_target;
  output reg [9:0] pc;
  output reg push_valid;
  output reg [9:0] push_addr;
  input wire flag_we;
  input wire flag_c;
  input wire flag_dc;
  input wire flag_z_we;
  input wire flag_z;
  input wire clrwdt_exec;
  input wire sleep_exec;
  input wire wdt_timeout;
  input wire [1:0] t0_src;
  input wire t0_falling;
  input wire ext_timer_clock_pin;
  input wire low_osc_clk;
  input wire port_read_source_option;
  input wire [5:0] pin_is_output;
  input wire [5:0] port_b_pin;
  output reg [5:0] port_b_out;
  output reg ext_int_select;
  output reg watchdog_enable;
  output reg low_volt_detect_enable;
  output reg low_volt_reset_enable;
  output reg [5:0] pin_wakeup_enable;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  reg [7:0] timer0_r;
  reg [7:0] status_r;
  reg [7:0] fptr_r;
  reg [1:0] port_b_data_gp_r;
  reg [3:0] pwr_gp_r;
  // power control reset image, only the watchdog_enable bit is picked
  wire [7:0] pwr_rst;
  assign pwr_rst = `CSRB_RST_PWRCTL;
  reg [2:0] pc_high_buffer_r;
  reg [7:0] gpr_r [0:47];
  reg [5:0] pin_s1_r;
  reg [5:0] pin_s2_r;
  reg [1:0] tclk_s1_r;
  reg [1:0] tclk_s2_r;
  reg tclk_d_r;

  // indirect port redirects through the pointer, bank bits unused
  wire is_ind;
  wire [5:0] eff_addr;
  assign is_ind = (addr == `CSRB_A_INDIRECT);
  assign eff_addr = is_ind ? fptr_r[5:0] : addr;
  wire wr_hit;
  wire rd_hit;
  assign wr_hit = step & wr_en;
  assign rd_hit = step & rd_en;

  // ------------------------------------------------------------
  // timer0 source and edge
  // ------------------------------------------------------------
  // both external clocks pass two flip-flops before use
  wire tclk_sel;
  wire tclk_edge;
  wire t0_tick;
  assign tclk_sel = (t0_src == `CSRB_T0_LOWOSC) ? tclk_s2_r[1] :
                    tclk_s2_r[0];
  assign tclk_edge = t0_falling ? (tclk_d_r & ~tclk_sel) :
                     (~tclk_d_r & tclk_sel);
  assign t0_tick = (t0_src == `CSRB_T0_INST) ? step : tclk_edge;

  always @(posedge clk_sys) begin
    tclk_s1_r <= {low_osc_clk, ext_timer_clock_pin};
    tclk_s2_r <= tclk_s1_r;
    tclk_d_r <= tclk_sel;
    pin_s1_r <= port_b_pin;
    pin_s2_r <= pin_s1_r;
  end

  // write replaces the count, otherwise count on the tick
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      timer0_r <= `CSRB_RST_BYTE;
    end else if (wr_hit && eff_addr == `CSRB_A_TIMER0) begin
      timer0_r <= wdata;
    end else if (t0_tick) begin
      timer0_r <= timer0_r + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // program counter
  // ------------------------------------------------------------
  wire [9:0] pc_inc;
  assign pc_inc = pc + 10'h001;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      pc <= `CSRB_RST_PC;
      push_valid <= 1'b0;
      push_addr <= `CSRB_RST_PC;
    end else begin
      push_valid <= 1'b0;
      if (step) begin
        case (pc_op)
          `CSRB_PCOP_NEAR: begin
            pc <= {pc_high_buffer_r[1], instr_target[8:0]};
          end
          `CSRB_PCOP_SCALL: begin
            pc <= {pc_high_buffer_r[1:0], instr_target[7:0]};
            push_valid <= 1'b1;
            push_addr <= pc_inc;
          end
          `CSRB_PCOP_FAR: begin
            pc <= instr_target;
          end
          `CSRB_PCOP_FCALL: begin
            pc <= instr_target;
            push_valid <= 1'b1;
            push_addr <= pc_inc;
          end
          `CSRB_PCOP_HOLD: begin
            pc <= pc;
          end
          default: begin
            if (wr_en && eff_addr == `CSRB_A_PC_LOW) begin
              pc <= {pc_high_buffer_r[1:0], wdata};
            end else begin
              pc <= pc_inc;
            end
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      status_r <= `CSRB_RST_STATUS;
    end else begin
      if (wr_hit && eff_addr == `CSRB_A_STATUS) begin
        status_r <= wdata;
      end
      if (step && flag_we) begin
        status_r[`CSRB_ST_C] <= flag_c;
        status_r[`CSRB_ST_DC] <= flag_dc;
      end
      if (step && flag_z_we) begin
        status_r[`CSRB_ST_Z] <= flag_z;
      end
      if (step && clrwdt_exec) begin
        status_r[`CSRB_ST_PD] <= 1'b1;
        status_r[`CSRB_ST_TO] <= 1'b1;
      end
      if (step && sleep_exec) begin
        status_r[`CSRB_ST_PD] <= 1'b0;
        status_r[`CSRB_ST_TO] <= 1'b1;
      end
      if (wdt_timeout) begin
        status_r[`CSRB_ST_TO] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // pointer, port, power, wake, buffer, ram
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      fptr_r <= `CSRB_RST_FPTR;
      port_b_out <= 6'h00;
      port_b_data_gp_r <= 2'h0;
      watchdog_enable <= pwr_rst[`CSRB_PC_WATCHDOG_ENABLE];
      ext_int_select <= 1'b0;
      low_volt_detect_enable <= 1'b0;
      low_volt_reset_enable <= 1'b1;
      pwr_gp_r <= 4'h0;
      pin_wakeup_enable <= `CSRB_RST_WAKE;
      pc_high_buffer_r <= `CSRB_RST_PC_HIGH_BUFFER;
    end else if (wr_hit) begin
      case (eff_addr)
        `CSRB_A_FPTR: fptr_r <= wdata;
        `CSRB_A_PORT_B_DATA: begin
          port_b_out <= wdata[5:0];
          port_b_data_gp_r <= wdata[7:6];
        end
        `CSRB_A_PWRCTL: begin
          watchdog_enable <= wdata[`CSRB_PC_WATCHDOG_ENABLE];
          ext_int_select <= wdata[`CSRB_PC_EIS];
          low_volt_detect_enable <= wdata[`CSRB_PC_LOW_VOLT_DETECT_ENABLE];
          low_volt_reset_enable <= wdata[`CSRB_PC_LOW_VOLT_RESET_ENABLE];
          pwr_gp_r <= {wdata[4], wdata[2:0]};
        end
        `CSRB_A_WAKE: pin_wakeup_enable <= wdata[5:0];
        `CSRB_A_PC_HIGH_BUFFER: pc_high_buffer_r <= wdata[2:0];
        default: pc_high_buffer_r <= pc_high_buffer_r;
      endcase
    end
  end

  // general purpose ram above the special registers
  always @(posedge clk_sys) begin
    if (wr_hit && eff_addr >= `CSRB_GPR_BASE) begin
      gpr_r[eff_addr - `CSRB_GPR_BASE] <= wdata;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // outputs take pin or latch by option, inputs always pin
  wire [5:0] port_b_data_rd;
  assign port_b_data_rd = (pin_is_output & ~{6{port_read_source_option}} &
                     port_b_out) |
                    ((~pin_is_output | {6{port_read_source_option}}) &
                     pin_s2_r);

  reg [7:0] rd_nxt;
  always @* begin
    rd_nxt = 8'h00;
    case (eff_addr)
      `CSRB_A_TIMER0: rd_nxt = timer0_r;
      `CSRB_A_PC_LOW: rd_nxt = pc[7:0];
      `CSRB_A_STATUS: rd_nxt = status_r;
      `CSRB_A_FPTR: rd_nxt = fptr_r;
      `CSRB_A_PORT_B_DATA: rd_nxt = {port_b_data_gp_r, port_b_data_rd};
      `CSRB_A_PWRCTL: rd_nxt = {watchdog_enable, ext_int_select,
                                low_volt_detect_enable, pwr_gp_r[3],
                                low_volt_reset_enable, pwr_gp_r[2:0]};
      `CSRB_A_WAKE: rd_nxt = {2'h0, pin_wakeup_enable};
      `CSRB_A_PC_HIGH_BUFFER: rd_nxt = {5'h00, pc_high_buffer_r};
      default: begin
        if (eff_addr >= `CSRB_GPR_BASE) begin
          rd_nxt = gpr_r[eff_addr - `CSRB_GPR_BASE];
        end
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (rd_hit) begin
      rdata <= rd_nxt;
    end
  end
endmodule // csrb_core_special_register_bank

// File: rtl/csrb_consts.vh
// Purpose: constants for the core special register bank
// Assumes: 6-bit register file address, 8-bit data, 10-bit pc
// Notes: offsets are register indices within the bank
`ifndef CSRB_CONSTS_VH
`define CSRB_CONSTS_VH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CSRB_A_INDIRECT 6'h00
`define CSRB_A_TIMER0 6'h01
`define CSRB_A_PC_LOW 6'h02
`define CSRB_A_STATUS 6'h03
`define CSRB_A_FPTR 6'h04
`define CSRB_A_PORT_B_DATA 6'h06
`define CSRB_A_PWRCTL 6'h08
`define CSRB_A_WAKE 6'h09
`define CSRB_A_PC_HIGH_BUFFER 6'h0A
`define CSRB_GPR_BASE 6'h10
// ------------------------------------------------------------
// status bit positions
// ------------------------------------------------------------
`define CSRB_ST_C 0
`define CSRB_ST_DC 1
`define CSRB_ST_Z 2
`define CSRB_ST_PD 3
`define CSRB_ST_TO 4
// ------------------------------------------------------------
// power control bit positions
// ------------------------------------------------------------
`define CSRB_PC_LOW_VOLT_RESET_ENABLE 3
`define CSRB_PC_LOW_VOLT_DETECT_ENABLE 5
`define CSRB_PC_EIS 6
`define CSRB_PC_WATCHDOG_ENABLE 7
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CSRB_RST_STATUS 8'h18
`define CSRB_RST_PWRCTL 8'h88
`define CSRB_RST_WAKE 6'h3F
`define CSRB_RST_PC_HIGH_BUFFER 3'h0
`define CSRB_RST_PC 10'h000
`define CSRB_RST_FPTR 8'h00
`define CSRB_RST_BYTE 8'h00
// ------------------------------------------------------------
// pc load kinds
// ------------------------------------------------------------
`define CSRB_PCOP_STEP 3'h0
`define CSRB_PCOP_NEAR 3'h1
`define CSRB_PCOP_SCALL 3'h2
`define CSRB_PCOP_FAR 3'h3
`define CSRB_PCOP_FCALL 3'h4
`define CSRB_PCOP_HOLD 3'h5
// ------------------------------------------------------------
// timer0 source select
// ------------------------------------------------------------
`define CSRB_T0_INST 2'h0
`define CSRB_T0_EXT 2'h1
`define CSRB_T0_LOWOSC 2'h2
`endif

// File: bench/csrb_pins_model.sv
// Purpose: port b pins seen from outside the bank
// Assumes: outputs follow the latch, inputs follow the outside
// Notes: load_flip models an overloaded output pin
`timescale 1ns/1ns
module csrb_pins_model (
  input wire [5:0] port_b_out,
  input wire [5:0] pin_is_output,
  input wire [5:0] ext_level,
  input wire [5:0] load_flip,
  output wire [5:0] port_b_pin
);
  // pin level from driver or outside world
  assign port_b_pin = (pin_is_output & (port_b_out ^ load_flip)) |
    (~pin_is_output & ext_level);
endmodule // csrb_pins_model

// File: bench/csrb_checker_sva.sv
// Purpose: port checks of the register bank
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top
`timescale 1ns/1ns
module csrb_checker (
  input wire clk_sys,
  input wire rst_b,
  input wire step,
  input wire wr_en,
  input wire [5:0] addr,
  input wire [7:0] wdata,
  input wire [2:0] pc_op,
  input wire [9:0] instr_target,
  input wire [9:0] pc,
  input wire push_valid,
  input wire [9:0] push_addr,
  input wire [5:0] port_b_out,
  input wire ext_int_select,
  input wire watchdog_enable,
  input wire low_volt_detect_enable,
  input wire low_volt_reset_enable,
  input wire [5:0] pin_wakeup_enable
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  wire wr_step = step & wr_en;
  a_pc_advance: assert property (
    step && !wr_en && pc_op == 3'h0 |=> pc == $past(pc) + 10'h001)
    else $error("pc not stepped");
  a_near_jump: assert property (
    step && pc_op == 3'h1 |=> pc[8:0] == $past(instr_target[8:0]))
    else $error("near jump target");
  a_short_call: assert property (
    step && pc_op == 3'h2 |=>
    pc[7:0] == $past(instr_target[7:0]) && push_valid)
    else $error("short call");
  a_far_load: assert property (
    step && (pc_op == 3'h3 || pc_op == 3'h4) |=> pc == $past(instr_target))
    else $error("far load");
  a_far_push: assert property (
    step && pc_op == 3'h4 |=> push_addr == $past(pc) + 10'h001)
    else $error("far call push");
  a_no_push: assert property (
    !(step && (pc_op == 3'h2 || pc_op == 3'h4)) |=> !push_valid)
    else $error("stray push");
  a_port_latch: assert property (
    wr_step && addr == 6'h06 |=> port_b_out == $past(wdata[5:0]))
    else $error("port latch");
  a_power_bits: assert property (
    wr_step && addr == 6'h08 |=> low_volt_reset_enable == $past(wdata[3])
    && {watchdog_enable, ext_int_select, low_volt_detect_enable} ==
    $past(wdata[7:5]))
    else $error("power control bits");
  a_wake_bits: assert property (
    wr_step && addr == 6'h09 |=> pin_wakeup_enable == $past(wdata[5:0]))
    else $error("wake enables");
endmodule // csrb_checker

// File: bench/tb_core_special_register_bank.sv
// Purpose: self-checking bench of the register bank
// Assumes: one op is one step, read data the cycle after
// Notes: pc and high buffer are modelled here
`timescale 1ns/1ns
module tb_core_special_register_bank;
  reg clk_sys = 1'b0, rst_b = 1'b0, step = 1'b0, rd_en = 1'b0;
  reg wr_en = 1'b0, flag_we = 1'b0, flag_c = 1'b0, flag_dc = 1'b0;
  reg flag_z_we = 1'b0, flag_z = 1'b0, clrwdt_exec = 1'b0;
  reg sleep_exec = 1'b0, wdt_timeout = 1'b0, t0_falling = 1'b1;
  reg ext_timer_clock_pin = 1'b0, low_osc_clk = 1'b0;
  reg port_read_source_option = 1'b0;
  reg [5:0] addr = 6'h00, pin_is_output = 6'h00, ext_level = 6'h00;
  reg [5:0] load_flip = 6'h00;
  reg [7:0] wdata = 8'h00, v, b, side_fl = 8'h00;
  reg [2:0] pc_op = 3'h0;
  reg [9:0] instr_target = 10'h000, tgt = 10'h000, exp_pc = 10'h000;
  reg [1:0] t0_src = 2'h1, exp_hb = 2'h0;
  reg [4:0] side = 5'h00;
  reg [31:0] r;
  wire [7:0] rdata;
  wire [9:0] pc, push_addr;
  wire push_valid, ext_int_select, watchdog_enable;
  wire low_volt_detect_enable, low_volt_reset_enable;
  wire [5:0] port_b_pin, port_b_out, pin_wakeup_enable;
  integer seed = 32'h2488_bf14;
  integer err_count = 0, n_compared = 0, cyc = 0, i;
  csrb_core_special_register_bank i_csrb_core_special_register_bank (.*);
  csrb_pins_model i_csrb_pins_model (.port_b_out(port_b_out),
    .pin_is_output(pin_is_output), .ext_level(ext_level),
    .load_flip(load_flip), .port_b_pin(port_b_pin));
  // ----
  // clock, timeout, checks
  // ----
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      report_and_stop;
    end
  end
  task chk8(input [7:0] g, input [7:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[ERR] %0t byte %h want %h", $time, g, e);
      end
    end
  endtask
  task chk10(input [9:0] g, input [9:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[ERR] %0t pc %h want %h", $time, g, e);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // ----
  // expectations
  // ----
  function [9:0] next_pc(input [9:0] p, input [2:0] k, input wl,
    input [7:0] d);
    case (k)
      3'h1: next_pc = {exp_hb[1], tgt[8:0]};
      3'h2: next_pc = {exp_hb, tgt[7:0]};
      3'h3, 3'h4: next_pc = tgt;
      3'h5: next_pc = p;
      default: next_pc = wl ? {exp_hb, d} : p + 10'h001;
    endcase
  endfunction
  function [7:0] flags(input [7:0] x, input [7:0] y, input s);
    reg [8:0] q;
    reg [4:0] h;
    begin
      q = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
      h = s ? {1'b0, x[3:0]} - {1'b0, y[3:0]} :
        {1'b0, x[3:0]} + {1'b0, y[3:0]};
      flags = {5'h00, (x & y) == 8'h00, h[4] ^ s, q[8] ^ s};
    end
  endfunction
  function [7:0] port_exp(input [5:0] d);
    port_exp = {2'h0, (~pin_is_output & ext_level) | (pin_is_output &
      (port_read_source_option ? d ^ load_flip : d))};
  endfunction
  // ----
  // bus steps
  // ----
  task op(input w, input [5:0] a, input [7:0] d, input [2:0] k);
    reg [9:0] p;
    begin
      p = exp_pc;
      @(posedge clk_sys);
      {step, wr_en, rd_en, addr, wdata, pc_op} <= {1'b1, w, ~w, a, d, k};
      instr_target <= tgt;
      {flag_we, flag_z_we, clrwdt_exec, sleep_exec, wdt_timeout} <= side;
      {flag_z, flag_dc, flag_c} <= side_fl[2:0];
      @(posedge clk_sys);
      step <= 1'b0;
      {flag_we, flag_z_we, clrwdt_exec, sleep_exec, wdt_timeout} <= 5'h00;
      side = 5'h00;
      #1;
      exp_pc = next_pc(p, k, w && a == 6'h02, d);
      if (w && a == 6'h0A) exp_hb = d[1:0];
      chk10(pc, exp_pc);
      chk8({7'h00, push_valid}, {7'h00, k == 3'h2 || k == 3'h4});
      if (k == 3'h2 || k == 3'h4) chk10(push_addr, p + 10'h001);
    end
  endtask
  task rd(input [5:0] a, input [7:0] m, input [7:0] e);
    begin
      op(1'b0, a, 8'h00, 3'h0);
      chk8(rdata & m, e);
    end
  endtask
  task stat(input [4:0] s, input [7:0] m, input [7:0] e);
    begin
      side = s;
      op(1'b0, 6'h10, 8'h00, 3'h0);
      rd(6'h03, m, e);
    end
  endtask
  task pulses;
    begin
      repeat (3) begin
        repeat (3) @(posedge clk_sys);
        {ext_timer_clock_pin, low_osc_clk} <= 2'b11;
        repeat (3) @(posedge clk_sys);
        {ext_timer_clock_pin, low_osc_clk} <= 2'b00;
      end
      repeat (4) @(posedge clk_sys);
    end
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(6'h08, 8'hFF, 8'h88);
    rd(6'h03, 8'h18, 8'h18);
    chk8({2'h0, pin_wakeup_enable}, 8'h3F);
    for (i = 0; i < 60; i = i + 1) begin
      r = $random(seed);
      tgt = r[9:0];
      if (i % 7 == 0) op(1'b1, 6'h0A, r[17:10], 3'h0);
      else if (i % 11 == 0) op(1'b1, 6'h02, r[17:10], 3'h0);
      else op(1'b0, 6'h10, 8'h00, r[20:18] % 3'h6);
    end
    for (i = 0; i < 4; i = i + 1) begin
      r = $random(seed);
      {t0_src, t0_falling} <= {i < 2 ? 2'h1 : 2'h2, r[8]};
      op(1'b1, 6'h01, r[7:0], 3'h0);
      rd(6'h01, 8'hFF, r[7:0]);
      pulses;
      rd(6'h01, 8'hFF, r[7:0] + 8'h03);
    end
    // instruction clock source: one count per executed step
    t0_src <= 2'h0;
    r = $random(seed);
    op(1'b1, 6'h01, r[7:0], 3'h0);
    rd(6'h01, 8'hFF, r[7:0]);
    rd(6'h01, 8'hFF, r[7:0] + 8'h01);
    for (i = 0; i < 12; i = i + 1) begin
      r = $random(seed);
      {v, b} = r[15:0];
      side_fl = flags(v, b, r[16]);
      stat(5'h18, 8'h07, side_fl);
      op(1'b1, 6'h08, v, 3'h0);
      rd(6'h08, 8'hFF, v);
      op(1'b1, 6'h09, v, 3'h0);
      rd(6'h09, 8'h3F, v & 8'h3F);
      op(1'b1, 6'h03, v, 3'h0);
      rd(6'h03, 8'hE0, v & 8'hE0);
      op(1'b1, 6'h0A, v, 3'h0);
      rd(6'h0A, 8'h07, v & 8'h07);
      op(1'b1, 6'h05, v, 3'h0);
      rd(6'h05, 8'hFF, 8'h00);
      op(1'b1, 6'h04, {b[7:6], 1'b1, b[4:0]}, 3'h0);
      op(1'b1, 6'h00, ~v, 3'h0);
      rd({1'b1, b[4:0]}, 8'hFF, ~v);
      rd(6'h00, 8'hFF, ~v);
      {port_read_source_option, pin_is_output, ext_level} <= r[31:19];
      load_flip <= r[22:17];
      op(1'b1, 6'h06, b, 3'h0);
      chk8({2'h0, port_b_out}, b & 8'h3F);
      repeat (3) @(posedge clk_sys);
      rd(6'h06, 8'h3F, port_exp(b[5:0]));
    end
    stat(5'h02, 8'h18, 8'h10);
    stat(5'h04, 8'h18, 8'h18);
    stat(5'h01, 8'h18, 8'h08);
    report_and_stop;
  end
endmodule // tb_core_special_register_bank
bind csrb_core_special_register_bank csrb_checker i_csrb_checker (.*);
